// [src/ptg_consts.svh]
// offsets, field positions, reset values and read constants of the timer group
// assumes byte addresses on an 8-bit address port, 16-bit data
`ifndef PTG_CONSTS_SVH
`define PTG_CONSTS_SVH

`define PTG_NUM_TMR      6
`define PTG_ADDR_W       8
`define PTG_DATA_W       16

`define PTG_OFS_MODE     8'h00
`define PTG_OFS_CNT      8'h10
`define PTG_OFS_START    8'h20
`define PTG_OFS_PRESC    8'h21
`define PTG_OFS_IRQ_STAT 8'h22
`define PTG_OFS_IRQ_MASK 8'h23
`define PTG_OFS_PIN      8'h24

`define PTG_MR_MODE_LSB  0
`define PTG_MR_MODE_MSB  1
`define PTG_MR_OPT_LO    2
`define PTG_MR_OPT_HI    3
`define PTG_MR_BIT4      4
`define PTG_MR_OVF       5
`define PTG_MR_SRC       6
`define PTG_MR_EVT       7

`define PTG_MODE_RST     8'h00
`define PTG_PRESC_RST    8'h00
`define PTG_CNT_RST      16'h0000
`define PTG_RELOAD_READ  16'hFFFF
`define PTG_CNT_MAX      16'hFFFF

`endif

// [src/ptg_pin_sync.sv]
// three-flop synchroniser with edge pulses for one timer input pin
// assumes an asynchronous pin; i_rstn synchronous active low
module ptg_pin_sync (
    input  wire logic i_clk_sys,
    input  wire logic i_rstn,
    input  wire logic i_pin,
    output logic      o_level,
    output logic      o_rise,
    output logic      o_fall
);
    logic s1_q, s2_q, s3_q;
    logic level_q, level_d;
    logic rise_q, rise_d, fall_q, fall_d;

    // level only moves once second and third stages agree
    always_comb begin
        level_d = (s2_q == s3_q) ? s2_q : level_q;
        rise_d  = level_d & ~level_q;
        fall_d  = ~level_d & level_q;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            s1_q    <= 1'b0;
            s2_q    <= 1'b0;
            s3_q    <= 1'b0;
            level_q <= 1'b0;
            rise_q  <= 1'b0;
            fall_q  <= 1'b0;
        end else begin
            s1_q    <= i_pin;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            level_q <= level_d;
            rise_q  <= rise_d;
            fall_q  <= fall_d;
        end
    end

    assign o_level = level_q;
    assign o_rise  = rise_q;
    assign o_fall  = fall_q;
endmodule

// [src/ptg_pkg.sv]
// types shared by the timer group
// assumes ptg_consts.svh for all numeric values
package ptg_pkg;
    typedef enum logic [1:0] {
        PTG_TIMER,
        PTG_EVENT,
        PTG_MEASURE,
        PTG_RESERVED
    } ptg_mode_e;

    typedef logic [15:0] ptg_word_t;
endpackage

// [src/ptg_top.sv]
// six 16-bit timers: timer, event counter and pulse period/width measurement
// assumes a one-cycle strobe register port; read data the cycle after the strobe
// How it works
// - after reset all timers stop; each runs only once its start flag is one
// - timer and event modes read the live count, but FFFFh in a reload cycle
// - before start, or after a stopped write, the counter reads the written value
// - event source select one counts every request of the chosen timer, unmasked
// - a measuring timer feeds others events on overflow and on every active edge after the first
// - mode write with bit 4 zero while running clears the overflow flag
// - measurement modes raise a request on each overflow and each active edge after the first
// - the overflow flag in the mode register tells overflow from edge requests
// - first edge after start captures a meaningless count and raises no request
// - counter resets to a fixed value; counting from it may overflow before edges
// - a counter write while stopped loads both counter and reload register
// - period mode: edge with overflow gives one request and no measurement
// - width mode measures high and low widths back to back; pin level is readable
//
// Chosen here: the address map and the address-and-strobe port.
`include "ptg_consts.svh"
module ptg_top #(
    parameter int NUM_TMR = `PTG_NUM_TMR
) (
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_rstn,
    input  wire logic [`PTG_ADDR_W-1:0] i_addr,
    input  wire logic [`PTG_DATA_W-1:0] i_wdata,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    input  wire logic [NUM_TMR-1:0]     i_measure_input_pin,
    output logic      [`PTG_DATA_W-1:0] o_rdata,
    output logic                        o_irq,
    output logic      [NUM_TMR-1:0]     o_timer_req
);
    logic [NUM_TMR-1:0] start_q, start_d;
    logic [7:0]         presc_q, presc_d;
    logic [7:0]         pdiv_q, pdiv_d;
    logic               ptick_q, ptick_d;
    logic [NUM_TMR-1:0] stat_q, stat_d;
    logic [NUM_TMR-1:0] mask_q, mask_d;
    logic               irq_q, irq_d;
    logic [`PTG_DATA_W-1:0] rdata_q, rdata_d;

    logic [NUM_TMR-1:0] pin_level, pin_rise, pin_fall;
    logic [NUM_TMR-1:0] req_vec;

    logic [7:0]         cfg_q  [NUM_TMR];
    logic [7:0]         cfg_d  [NUM_TMR];
    logic               ovf_q  [NUM_TMR];
    logic               ovf_d  [NUM_TMR];
    ptg_pkg::ptg_word_t cnt_q  [NUM_TMR];
    ptg_pkg::ptg_word_t cnt_d  [NUM_TMR];
    ptg_pkg::ptg_word_t rld_q  [NUM_TMR];
    ptg_pkg::ptg_word_t rld_d  [NUM_TMR];
    logic               first_q[NUM_TMR];
    logic               first_d[NUM_TMR];
    logic               req_q  [NUM_TMR];
    logic               req_d  [NUM_TMR];
    logic               reload_now[NUM_TMR];

    // shared prescaler: count source when count_source_select is one
    always_comb begin
        ptick_d = (pdiv_q == presc_q);
        pdiv_d  = ptick_d ? 8'h00 : pdiv_q + 8'h01;
        presc_d = presc_q;
        start_d = start_q;
        mask_d  = mask_q;
        if (i_wr && (i_addr == `PTG_OFS_PRESC) && (start_q == '0)) begin
            presc_d = i_wdata[7:0];
        end
        if (i_wr && (i_addr == `PTG_OFS_START)) begin
            start_d = i_wdata[NUM_TMR-1:0];
        end
        if (i_wr && (i_addr == `PTG_OFS_IRQ_MASK)) begin
            mask_d = i_wdata[NUM_TMR-1:0];
        end
        for (int k = 0; k < NUM_TMR; k++) begin
            req_vec[k] = req_q[k];
        end
        // a request in the clearing cycle survives
        stat_d = stat_q;
        if (i_wr && (i_addr == `PTG_OFS_IRQ_STAT)) begin
            stat_d = stat_q & ~i_wdata[NUM_TMR-1:0];
        end
        stat_d = stat_d | req_vec;
        irq_d  = |(stat_q & mask_q);
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            start_q <= '0;
            presc_q <= `PTG_PRESC_RST;
            pdiv_q  <= 8'h00;
            ptick_q <= 1'b0;
            stat_q  <= '0;
            mask_q  <= '0;
            irq_q   <= 1'b0;
        end else begin
            start_q <= start_d;
            presc_q <= presc_d;
            pdiv_q  <= pdiv_d;
            ptick_q <= ptick_d;
            stat_q  <= stat_d;
            mask_q  <= mask_d;
            irq_q   <= irq_d;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_TMR; g++) begin : g_tmr
            localparam int PREV = (g == 0) ? NUM_TMR - 1 : g - 1;
            logic wr_mode, wr_cnt, run, tick, pin_ev, ev, act_edge, width, ovf_ev;
            ptg_pkg::ptg_mode_e mode;

            ptg_pin_sync u_sync (
                .i_clk_sys (i_clk_sys),
                .i_rstn    (i_rstn),
                .i_pin     (i_measure_input_pin[g]),
                .o_level   (pin_level[g]),
                .o_rise    (pin_rise[g]),
                .o_fall    (pin_fall[g])
            );

            always_comb begin
                wr_mode  = i_wr && (i_addr == (`PTG_OFS_MODE | 8'(g)));
                wr_cnt   = i_wr && (i_addr == (`PTG_OFS_CNT | 8'(g)));
                run      = start_q[g];
                mode     = ptg_pkg::ptg_mode_e'(cfg_q[g][`PTG_MR_MODE_MSB:`PTG_MR_MODE_LSB]);
                tick     = cfg_q[g][`PTG_MR_SRC] ? ptick_q : 1'b1;
                width    = cfg_q[g][`PTG_MR_OPT_HI];
                // falling edge by default, rising with option low set, both in width
                act_edge = width ? (pin_rise[g] | pin_fall[g]) :
                           (cfg_q[g][`PTG_MR_OPT_LO] ? pin_rise[g] : pin_fall[g]);
                pin_ev   = act_edge;
                // the chosen timer's request counts whatever its mask says
                ev       = cfg_q[g][`PTG_MR_EVT] ? req_q[PREV] : pin_ev;
                ovf_ev   = tick && (cnt_q[g] == `PTG_CNT_MAX);
                cfg_d[g]      = cfg_q[g];
                ovf_d[g]      = ovf_q[g];
                cnt_d[g]      = cnt_q[g];
                rld_d[g]      = rld_q[g];
                first_d[g]    = first_q[g];
                req_d[g]      = 1'b0;
                reload_now[g] = 1'b0;
                if (wr_mode) begin
                    if (!run) begin
                        cfg_d[g] = i_wdata[7:0];
                    end
                    if (!i_wdata[`PTG_MR_BIT4]) begin
                        ovf_d[g] = 1'b0;
                    end
                end
                if (wr_cnt) begin
                    rld_d[g] = i_wdata;
                    if (!run) begin
                        cnt_d[g] = i_wdata;
                    end
                end
                if (!run) begin
                    first_d[g] = 1'b0;
                end else begin
                    case (mode)
                        ptg_pkg::PTG_TIMER, ptg_pkg::PTG_EVENT: begin
                            if ((mode == ptg_pkg::PTG_TIMER) ? tick : ev) begin
                                if (cnt_q[g] == `PTG_CNT_RST) begin
                                    cnt_d[g]      = rld_q[g];
                                    req_d[g]      = 1'b1;
                                    reload_now[g] = 1'b1;
                                end else begin
                                    cnt_d[g] = cnt_q[g] - 16'h0001;
                                end
                            end
                        end
                        ptg_pkg::PTG_MEASURE: begin
                            if (tick) begin
                                cnt_d[g] = cnt_q[g] + 16'h0001;
                            end
                            if (ovf_ev) begin
                                ovf_d[g] = 1'b1;
                                req_d[g] = 1'b1;
                            end
                            // period mode drops an edge that meets an overflow
                            if (act_edge && !(ovf_ev && !width)) begin
                                rld_d[g]   = cnt_q[g];
                                cnt_d[g]   = `PTG_CNT_RST;
                                first_d[g] = 1'b1;
                                if (first_q[g]) begin
                                    req_d[g] = 1'b1;
                                end // else first edge: capture only
                            end
                        end
                        default: begin
                            cnt_d[g] = cnt_q[g];
                        end
                    endcase
                end
            end

            always_ff @(posedge i_clk_sys) begin
                if (!i_rstn) begin
                    cfg_q[g]   <= `PTG_MODE_RST;
                    ovf_q[g]   <= 1'b0;
                    cnt_q[g]   <= `PTG_CNT_RST;
                    rld_q[g]   <= `PTG_CNT_RST;
                    first_q[g] <= 1'b0;
                    req_q[g]   <= 1'b0;
                end else begin
                    cfg_q[g]   <= cfg_d[g];
                    ovf_q[g]   <= ovf_d[g];
                    cnt_q[g]   <= cnt_d[g];
                    rld_q[g]   <= rld_d[g];
                    first_q[g] <= first_d[g];
                    req_q[g]   <= req_d[g];
                end
            end

            assign o_timer_req[g] = req_q[g];
        end
    endgenerate

    // read path; unmapped addresses read zero
    always_comb begin
        rdata_d = 16'h0000;
        if (i_rd) begin
            for (int k = 0; k < NUM_TMR; k++) begin
                if (i_addr == (`PTG_OFS_MODE | 8'(k))) begin
                    rdata_d = {8'h00, cfg_q[k][7:6], ovf_q[k], 1'b0, cfg_q[k][3:0]};
                end
                if (i_addr == (`PTG_OFS_CNT | 8'(k))) begin
                    if (cfg_q[k][`PTG_MR_MODE_MSB:`PTG_MR_MODE_LSB] ==
                        2'(ptg_pkg::PTG_MEASURE)) begin
                        rdata_d = rld_q[k];
                    end else if (reload_now[k]) begin
                        rdata_d = `PTG_RELOAD_READ;
                    end else begin
                        rdata_d = cnt_q[k];
                    end
                end
            end
            case (i_addr)
                `PTG_OFS_START:    rdata_d = 16'(start_q);
                `PTG_OFS_PRESC:    rdata_d = {8'h00, presc_q};
                `PTG_OFS_IRQ_STAT: rdata_d = 16'(stat_q);
                `PTG_OFS_IRQ_MASK: rdata_d = 16'(mask_q);
                `PTG_OFS_PIN:      rdata_d = 16'(pin_level);
                default:           rdata_d = rdata_d;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_irq   = irq_q;
endmodule

// [tb/ptg_pulse_src.sv]
// pulse source model on the timer input pins
// assumes the bench clock; half period given in clocks
module ptg_pulse_src (
    input  wire logic       i_clk_sys,
    input  wire logic       i_en,
    input  wire logic [7:0] i_half,
    output logic            o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q = 8'h00;
    initial o_pin = 1'b0;
    always @(posedge i_clk_sys) begin
        if (!i_en) begin
            cnt_q <= 8'h00;
            o_pin <= 1'b0;  // idle low so no stray edge
        end else if (cnt_q == i_half - 8'h01) begin
            cnt_q <= 8'h00;
            o_pin <= ~o_pin;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule

// [tb/ptg_top_asserts.sv]
// checker of the register port and request outputs
// assumes it is bound to ptg_top and sees only its ports
`include "ptg_consts.svh"
module ptg_top_asserts #(
    parameter int NUM_TMR = `PTG_NUM_TMR
) (
    input wire logic                   i_clk_sys,
    input wire logic                   i_rstn,
    input wire logic [`PTG_ADDR_W-1:0] i_addr,
    input wire logic [`PTG_DATA_W-1:0] i_wdata,
    input wire logic                   i_wr,
    input wire logic                   i_rd,
    input wire logic [NUM_TMR-1:0]     i_measure_input_pin,
    input wire logic [`PTG_DATA_W-1:0] o_rdata,
    input wire logic                   o_irq,
    input wire logic [NUM_TMR-1:0]     o_timer_req
);
    logic [NUM_TMR-1:0] run_q, run_d;
    logic               go_q, go_d;
    logic               msk_q, msk_d;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    always_comb begin
        run_d = run_q;
        go_d = go_q;
        msk_d = msk_q;
        if (i_wr && i_addr == `PTG_OFS_START) begin
            run_d = i_wdata[NUM_TMR-1:0];
            go_d = go_q | (|i_wdata[NUM_TMR-1:0]);
        end
        if (i_wr && i_addr == `PTG_OFS_IRQ_MASK) msk_d = msk_q | (|i_wdata);
    end
    always_ff @(posedge i_clk_sys) begin
        run_q <= i_rstn ? run_d : '0;
        go_q  <= i_rstn ? go_d : 1'b0;
        msk_q <= i_rstn ? msk_d : 1'b0;
    end
    property p_rst_out;
        $rose(i_rstn) |-> o_timer_req == '0 && !o_irq && o_rdata == '0;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
    property p_rd_idle;
        !$past(i_rd) |-> o_rdata == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_unmapped;
        $past(i_rd) && $past(i_addr) > `PTG_OFS_PIN |-> o_rdata == '0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_mode_fields;
        $past(i_rd) && $past(i_addr) < NUM_TMR |-> o_rdata[15:8] == '0 && !o_rdata[4];
    endproperty
    a_mode_fields: assert property (p_mode_fields) else $error("mode read bad");
    property p_req_pulse;
        o_timer_req != '0 |=> (o_timer_req & $past(o_timer_req)) == '0;
    endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("request longer than one cycle");
    property p_stopped_quiet;
        !go_q |-> o_timer_req == '0;
    endproperty
    a_stopped_quiet: assert property (p_stopped_quiet) else $error("request before start");
    property p_mask_quiet;
        !msk_q |-> !o_irq;
    endproperty
    a_mask_quiet: assert property (p_mask_quiet) else $error("irq with empty mask");
    property p_wr_read;
        i_wr && i_addr >= `PTG_OFS_CNT && i_addr < `PTG_OFS_CNT + NUM_TMR && run_q == '0
        ##2 (i_rd && i_addr == $past(i_addr, 2)) |=> o_rdata == $past(i_wdata, 3);
    endproperty
    a_wr_read: assert property (p_wr_read) else $error("stopped write not read back");
endmodule
bind ptg_top ptg_top_asserts #(.NUM_TMR(NUM_TMR)) u_chk (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_measure_input_pin(i_measure_input_pin),
    .o_rdata(o_rdata), .o_irq(o_irq), .o_timer_req(o_timer_req));

// [tb/pulse_measure_timer_group_tb.sv]
// self-checking bench of the timer group
// assumes ptg_top register port; one pulse source feeds every pin
module pulse_measure_timer_group_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        src_en = 1'b0;
    logic        pin;
    logic [15:0] rdata, v;
    logic        irq;
    logic [5:0]  req, s;
    int          n_fail = 0;
    int          num_checks = 0;
    int          n;
    localparam logic [7:0]  RA[8] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h21, 8'h30};
    localparam logic [15:0] RD[8] = '{16'h0004, 16'h0000, 16'hFFF0, 16'h0000, 16'h1234,
                                      16'hFFFF, 16'h0003, 16'h5555};
    localparam logic [15:0] RE[8] = '{16'h0004, 16'h0000, 16'hFFF0, 16'h0000, 16'h1234,
                                      16'hFFFF, 16'h0003, 16'h0000};
    always #5 clk = ~clk;
    ptg_pulse_src src (.i_clk_sys(clk), .i_en(src_en), .i_half(8'h14), .o_pin(pin));
    ptg_top dut (.i_clk_sys(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
                 .i_rd(rd), .i_measure_input_pin({6{pin}}), .o_rdata(rdata), .o_irq(irq),
                 .o_timer_req(req));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask
    // requests are one-cycle pulses, so sample mid-cycle
    task automatic watch(input int m, output logic [5:0] o, output int c);
        o = 6'h00;
        c = 0;
        repeat (m) begin
            @(negedge clk);
            o |= req;
            c += int'(req[1]);
        end
        @(posedge clk);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge clk);
        n_fail++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            rd_reg(8'(i), v);
            chk(v, 16'h0000);
        end
        chk({14'h0000, irq, |req}, 16'h0000);
        rd_reg(8'h24, v);
        chk(v, 16'h0000);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            wr_reg(RA[i], RD[i]);
            rd_reg(RA[i], v);
            chk(v, RE[i]);
        end
        $display("table test done");
        wr_reg(8'h01, 16'h0006);
        wr_reg(8'h02, 16'h0002);
        wr_reg(8'h03, 16'h0081);
        wr_reg(8'h23, 16'h0001);
        repeat (30) @(posedge clk);
        chk({15'h0000, |req}, 16'h0000);
        wr_reg(8'h20, 16'h0001);
        watch(20, s, n);
        chk({10'h000, s}, 16'h0001);
        rd_reg(8'h10, v);
        chk({15'h0000, v <= 16'h0004 || v === 16'hFFFF}, 16'h0001);
        chk({15'h0000, irq}, 16'h0001);
        wr_reg(8'h00, 16'h0002);
        rd_reg(8'h00, v);
        chk(v & 16'h0003, 16'h0000);
        wr_reg(8'h20, 16'h0000);
        wr_reg(8'h22, 16'h0001);
        rd_reg(8'h22, v);
        chk(v & 16'h0001, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        $display("timer test done");
        wr_reg(8'h20, 16'h0002);
        src_en <= 1'b1;
        watch(90, s, n);
        chk(16'(n), 16'h0001);
        rd_reg(8'h11, v);
        chk({15'h0000, v >= 16'h0026 && v <= 16'h002A}, 16'h0001);
        src_en <= 1'b0;
        wr_reg(8'h20, 16'h0000);
        $display("measure test done");
        wr_reg(8'h20, 16'h000C);
        watch(40, s, n);
        chk({10'h000, s}, 16'h000C);
        rd_reg(8'h02, v);
        chk(v, 16'h0022);
        wr_reg(8'h02, 16'h0002);
        rd_reg(8'h02, v);
        chk(v, 16'h0002);
        $display("overflow test done");
        wr_reg(8'h04, 16'h000A);
        wr_reg(8'h20, 16'h0010);
        src_en <= 1'b1;
        watch(70, s, n);
        chk({10'h000, s}, 16'h0010);
        rd_reg(8'h14, v);
        chk(v, 16'h0013);
        src_en <= 1'b0;
        $display("width test done");
        end_of_test();
    end
endmodule
